// ### rtcac_pkg.sv
// Constants and types for the alarm, control and status block
package rtcac_pkg;

  // Register offsets
  localparam logic [4:0] ADDR_ALARM_A_SEC  = 5'h07;
  localparam logic [4:0] ADDR_ALARM_A_MIN  = 5'h08;
  localparam logic [4:0] ADDR_ALARM_A_HOUR = 5'h09;
  localparam logic [4:0] ADDR_ALARM_A_DAY  = 5'h0A;
  localparam logic [4:0] ADDR_ALARM_B_MIN  = 5'h0B;
  localparam logic [4:0] ADDR_ALARM_B_HOUR = 5'h0C;
  localparam logic [4:0] ADDR_ALARM_B_DAY  = 5'h0D;
  localparam logic [4:0] ADDR_CONTROL      = 5'h0E;
  localparam logic [4:0] ADDR_STATUS       = 5'h0F;
  localparam logic [4:0] ADDR_CHARGER      = 5'h10;

  // Field positions
  localparam int MASK_BIT        = 7;
  localparam int SELECT_BIT      = 6;
  localparam int CTL_OSC_RUN_N   = 7;
  localparam int CTL_BACKUP_OUT  = 5;
  localparam int CTL_RATE_HI     = 4;
  localparam int CTL_RATE_LO     = 3;
  localparam int CTL_IRQ_MODE    = 2;
  localparam int CTL_B_IRQ_EN    = 1;
  localparam int CTL_A_IRQ_EN    = 0;
  localparam int STS_OSC_HALT    = 7;
  localparam int STS_B_FLAG      = 1;
  localparam int STS_A_FLAG      = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h18;
  localparam logic [7:0] STATUS_RESET  = 8'h80;
  localparam logic [7:0] CHARGER_RESET = 8'h00;
  localparam logic [7:0] ALARM_RESET   = 8'h00;

  // Charger decode
  localparam logic [3:0] CHARGER_KEY = 4'hA;
  localparam logic [1:0] DIODE_NONE  = 2'h1;
  localparam logic [1:0] DIODE_ONE   = 2'h2;
  localparam logic [1:0] RES_OFF     = 2'h0;

  // Oscillator divider taps, counted in oscillator rising edges
  localparam int DIV_WIDTH   = 15;
  localparam int TAP_1HZ     = 14;
  localparam int TAP_8K      = 1;
  localparam int TAP_4K      = 2;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int OSC_STALL_NS  = 4000;
  localparam int OSC_STALL_CYCLES = (OSC_STALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OSC_STOPPED  = 3'h1,
    OSC_STARTING = 3'h2,
    OSC_RUNNING  = 3'h4
  } rtcac_osc_state_type;

endpackage : rtcac_pkg

// ### rtcac_alarm_match.sv
// Field-wise alarm comparator shared by both alarms
module rtcac_alarm_match (
  // Alarm settings
  input  wire logic [7:0] alarm_sec_i,
  input  wire logic [7:0] alarm_min_i,
  input  wire logic [7:0] alarm_hour_i,
  input  wire logic [7:0] alarm_day_i,
  // Current time
  input  wire logic [7:0] time_sec_i,
  input  wire logic [7:0] time_min_i,
  input  wire logic [7:0] time_hour_i,
  input  wire logic [7:0] time_weekday_i,
  input  wire logic [7:0] time_date_i,
  // Result
  output logic            match_o
);

  logic       sec_ok;
  logic       min_ok;
  logic       hour_ok;
  logic       day_ok;
  logic [5:0] day_ref;

  // Mask and select bits stay out of the compare
  assign sec_ok  = alarm_sec_i[rtcac_pkg::MASK_BIT]
                 | (alarm_sec_i[6:0] == time_sec_i[6:0]);
  assign min_ok  = alarm_min_i[rtcac_pkg::MASK_BIT]
                 | (alarm_min_i[6:0] == time_min_i[6:0]);
  assign hour_ok = alarm_hour_i[rtcac_pkg::MASK_BIT]
                 | (alarm_hour_i[6:0] == time_hour_i[6:0]);
  assign day_ref = alarm_day_i[rtcac_pkg::SELECT_BIT] ? time_weekday_i[5:0]
                                                      : time_date_i[5:0];
  assign day_ok  = alarm_day_i[rtcac_pkg::MASK_BIT]
                 | (alarm_day_i[5:0] == day_ref);
  // Masked fields always agree, so all-masked fires on every evaluation
  assign match_o = sec_ok & min_ok & hour_ok & day_ok;

endmodule : rtcac_alarm_match

// ### rtcac_core.sv
// Alarm, control, status and charger register logic of the clock
module rtcac_core #(
  parameter int STALL_CYCLES = rtcac_pkg::OSC_STALL_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Register access from the serial slave
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  output logic      [7:0] reg_rdata_o,
  // Timekeeping counters
  input  wire logic       time_update_i,
  input  wire logic [7:0] time_sec_i,
  input  wire logic [7:0] time_min_i,
  input  wire logic [7:0] time_hour_i,
  input  wire logic [7:0] time_weekday_i,
  input  wire logic [7:0] time_date_i,
  output logic            second_tick_o,
  // Oscillator and supply
  input  wire logic       osc_clk_i,
  input  wire logic       backup_active_i,
  output logic            osc_enable_o,
  // Shared output pin
  output logic            wave_or_irq_pin_o,
  output logic            wave_or_irq_pin_oe_n_o,
  // Charger selection
  output logic            charger_enable_o,
  output logic            charger_diode_o,
  output logic      [1:0] charger_res_sel_o
);

  logic [7:0] alarm_a_sec;
  logic [7:0] alarm_a_min;
  logic [7:0] alarm_a_hour;
  logic [7:0] alarm_a_day;
  logic [7:0] alarm_b_min;
  logic [7:0] alarm_b_hour;
  logic [7:0] alarm_b_day;
  logic [7:0] control;
  logic [7:0] charger_config;
  logic       osc_halt_flag;
  logic       alarm_a_flag;
  logic       alarm_b_flag;
  logic       match_a;
  logic       match_b;
  logic       wr_status;
  logic       wr_control;
  logic       osc_stop_event;
  logic       next_osc_halt_flag;
  logic       next_alarm_a_flag;
  logic       next_alarm_b_flag;
  logic [7:0] next_rdata;

  logic       osc_run_n;
  logic       backup_output_enable;
  logic       rate_select_hi;
  logic       rate_select_lo;
  logic       irq_mode_select;
  logic       alarm_b_irq_enable;
  logic       alarm_a_irq_enable;

  localparam int DIV_W = rtcac_pkg::DIV_WIDTH;

  logic [2:0] osc_sync;
  logic       osc_level;
  logic       osc_rise;
  logic [2:0] backup_sync;
  logic       backup_level;
  logic [DIV_W-1:0] div_count;
  logic [15:0] stall_count;
  logic       stall_event;
  rtcac_pkg::rtcac_osc_state_type osc_state;
  rtcac_pkg::rtcac_osc_state_type next_osc_state;

  logic       irq_active;
  logic       wave_level;
  logic       pin_float;
  logic       next_pin_o;
  logic       next_pin_oe_n;

  assign osc_run_n            = control[rtcac_pkg::CTL_OSC_RUN_N];
  assign backup_output_enable = control[rtcac_pkg::CTL_BACKUP_OUT];
  assign rate_select_hi       = control[rtcac_pkg::CTL_RATE_HI];
  assign rate_select_lo       = control[rtcac_pkg::CTL_RATE_LO];
  assign irq_mode_select      = control[rtcac_pkg::CTL_IRQ_MODE];
  assign alarm_b_irq_enable   = control[rtcac_pkg::CTL_B_IRQ_EN];
  assign alarm_a_irq_enable   = control[rtcac_pkg::CTL_A_IRQ_EN];

  assign wr_status  = reg_wr_i && (reg_addr_i == rtcac_pkg::ADDR_STATUS);
  assign wr_control = reg_wr_i && (reg_addr_i == rtcac_pkg::ADDR_CONTROL);

  // Register writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      alarm_a_sec    <= rtcac_pkg::ALARM_RESET;
      alarm_a_min    <= rtcac_pkg::ALARM_RESET;
      alarm_a_hour   <= rtcac_pkg::ALARM_RESET;
      alarm_a_day    <= rtcac_pkg::ALARM_RESET;
      alarm_b_min    <= rtcac_pkg::ALARM_RESET;
      alarm_b_hour   <= rtcac_pkg::ALARM_RESET;
      alarm_b_day    <= rtcac_pkg::ALARM_RESET;
      control        <= rtcac_pkg::CONTROL_RESET;
      charger_config <= rtcac_pkg::CHARGER_RESET;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        rtcac_pkg::ADDR_ALARM_A_SEC:  alarm_a_sec    <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_A_MIN:  alarm_a_min    <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_A_HOUR: alarm_a_hour   <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_A_DAY:  alarm_a_day    <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_B_MIN:  alarm_b_min    <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_B_HOUR: alarm_b_hour   <= reg_wdata_i;
        rtcac_pkg::ADDR_ALARM_B_DAY:  alarm_b_day    <= reg_wdata_i;
        // Bit 6 of control is fixed at zero
        rtcac_pkg::ADDR_CONTROL:      control        <= reg_wdata_i & 8'hBF;
        rtcac_pkg::ADDR_CHARGER:      charger_config <= reg_wdata_i;
        default:                      control        <= control;
      endcase
    end
  end

  // Alarm compare; alarm B has no seconds register and fires at second zero
  rtcac_alarm_match u_match_a (
    .alarm_sec_i    (alarm_a_sec),
    .alarm_min_i    (alarm_a_min),
    .alarm_hour_i   (alarm_a_hour),
    .alarm_day_i    (alarm_a_day),
    .time_sec_i     (time_sec_i),
    .time_min_i     (time_min_i),
    .time_hour_i    (time_hour_i),
    .time_weekday_i (time_weekday_i),
    .time_date_i    (time_date_i),
    .match_o        (match_a)
  );

  rtcac_alarm_match u_match_b (
    .alarm_sec_i    (8'h00),
    .alarm_min_i    (alarm_b_min),
    .alarm_hour_i   (alarm_b_hour),
    .alarm_day_i    (alarm_b_day),
    .time_sec_i     (time_sec_i),
    .time_min_i     (time_min_i),
    .time_hour_i    (time_hour_i),
    .time_weekday_i (time_weekday_i),
    .time_date_i    (time_date_i),
    .match_o        (match_b)
  );

  // Oscillator input: three stages, change accepted when last two agree
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      osc_sync  <= 3'h0;
      osc_level <= 1'b0;
    end
    else
    begin
      osc_sync <= {osc_sync[1:0], osc_clk_i};
      if (osc_sync[1] == osc_sync[2])
      begin
        osc_level <= osc_sync[2];
      end
    end
  end

  assign osc_rise = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_level;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      backup_sync  <= 3'h0;
      backup_level <= 1'b0;
    end
    else
    begin
      backup_sync <= {backup_sync[1:0], backup_active_i};
      if (backup_sync[1] == backup_sync[2])
      begin
        backup_level <= backup_sync[2];
      end
    end
  end

  // Divider runs only while the oscillator is enabled
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_count     <= '0;
      second_tick_o <= 1'b0;
    end
    else
    begin
      second_tick_o <= 1'b0;
      if (!osc_run_n && osc_rise)
      begin
        div_count     <= div_count + 1'b1;
        second_tick_o <= &div_count;
      end
    end
  end

  // Stall watchdog catches an oscillator that dies on its own
  always_ff @(posedge clk_i)
  begin
    if (reset_i || osc_rise || osc_run_n)
    begin
      stall_count <= 16'h0000;
    end
    else if (stall_count != 16'(STALL_CYCLES))
    begin
      stall_count <= stall_count + 16'h0001;
    end
  end

  assign stall_event = (stall_count == 16'(STALL_CYCLES - 1));

  always_comb
  begin
    next_osc_state = osc_state;
    case (osc_state)
      rtcac_pkg::OSC_STOPPED:
        if (!osc_run_n)
          next_osc_state = rtcac_pkg::OSC_STARTING;
      rtcac_pkg::OSC_STARTING:
        if (osc_run_n)
          next_osc_state = rtcac_pkg::OSC_STOPPED;
        else if (osc_rise)
          next_osc_state = rtcac_pkg::OSC_RUNNING;
      rtcac_pkg::OSC_RUNNING:
        if (osc_run_n || stall_event)
          next_osc_state = rtcac_pkg::OSC_STOPPED;
      default:
        next_osc_state = rtcac_pkg::OSC_STOPPED;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      osc_state    <= rtcac_pkg::OSC_STOPPED;
      osc_enable_o <= 1'b0;
    end
    else
    begin
      osc_state    <= next_osc_state;
      osc_enable_o <= !osc_run_n;
    end
  end

  // Edge triggered: leaving the running state is the stop event
  assign osc_stop_event = (osc_state == rtcac_pkg::OSC_RUNNING)
                       && (next_osc_state == rtcac_pkg::OSC_STOPPED);

  // Sticky flags: a set in the clearing cycle wins
  always_comb
  begin
    next_osc_halt_flag = osc_halt_flag;
    next_alarm_a_flag  = alarm_a_flag;
    next_alarm_b_flag  = alarm_b_flag;
    if (wr_status)
    begin
      next_osc_halt_flag = osc_halt_flag & reg_wdata_i[rtcac_pkg::STS_OSC_HALT];
      next_alarm_a_flag  = alarm_a_flag & reg_wdata_i[rtcac_pkg::STS_A_FLAG];
      next_alarm_b_flag  = alarm_b_flag & reg_wdata_i[rtcac_pkg::STS_B_FLAG];
    end
    if (osc_stop_event)
      next_osc_halt_flag = 1'b1;
    if (time_update_i && match_a)
      next_alarm_a_flag = 1'b1;
    if (time_update_i && match_b)
      next_alarm_b_flag = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      osc_halt_flag <= rtcac_pkg::STATUS_RESET[rtcac_pkg::STS_OSC_HALT];
      alarm_a_flag  <= rtcac_pkg::STATUS_RESET[rtcac_pkg::STS_A_FLAG];
      alarm_b_flag  <= rtcac_pkg::STATUS_RESET[rtcac_pkg::STS_B_FLAG];
    end
    else
    begin
      osc_halt_flag <= next_osc_halt_flag;
      alarm_a_flag  <= next_alarm_a_flag;
      alarm_b_flag  <= next_alarm_b_flag;
    end
  end

  // Read data, unmapped offsets read zero
  always_comb
  begin
    case (reg_addr_i)
      rtcac_pkg::ADDR_ALARM_A_SEC:  next_rdata = alarm_a_sec;
      rtcac_pkg::ADDR_ALARM_A_MIN:  next_rdata = alarm_a_min;
      rtcac_pkg::ADDR_ALARM_A_HOUR: next_rdata = alarm_a_hour;
      rtcac_pkg::ADDR_ALARM_A_DAY:  next_rdata = alarm_a_day;
      rtcac_pkg::ADDR_ALARM_B_MIN:  next_rdata = alarm_b_min;
      rtcac_pkg::ADDR_ALARM_B_HOUR: next_rdata = alarm_b_hour;
      rtcac_pkg::ADDR_ALARM_B_DAY:  next_rdata = alarm_b_day;
      rtcac_pkg::ADDR_CONTROL:      next_rdata = control;
      rtcac_pkg::ADDR_STATUS:       next_rdata = {osc_halt_flag, 5'h00, alarm_b_flag, alarm_a_flag};
      rtcac_pkg::ADDR_CHARGER:      next_rdata = charger_config;
      default:                      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= next_rdata;
  end

  // Shared pin: driven high and low unless floating, interrupt pulls low
  assign irq_active = (alarm_a_flag && alarm_a_irq_enable)
                   || (alarm_b_flag && alarm_b_irq_enable);

  always_comb
  begin
    case ({rate_select_hi, rate_select_lo})
      2'h0:    wave_level = div_count[rtcac_pkg::TAP_1HZ];
      2'h1:    wave_level = div_count[rtcac_pkg::TAP_4K];
      2'h2:    wave_level = div_count[rtcac_pkg::TAP_8K];
      default: wave_level = osc_level;
    endcase
  end

  // Stopped oscillator also freezes the wave
  assign pin_float = backup_level && !backup_output_enable;

  always_comb
  begin
    if (pin_float)
    begin
      next_pin_o    = 1'b1;
      next_pin_oe_n = 1'b1;
    end
    else if (irq_mode_select)
    begin
      next_pin_o    = !irq_active;
      next_pin_oe_n = 1'b0;
    end
    else
    begin
      next_pin_o    = wave_level;
      next_pin_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wave_or_irq_pin_o      <= 1'b1;
      wave_or_irq_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      wave_or_irq_pin_o      <= next_pin_o;
      wave_or_irq_pin_oe_n_o <= next_pin_oe_n;
    end
  end

  // Charger decode; the key guards against stray writes
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      charger_enable_o  <= 1'b0;
      charger_diode_o   <= 1'b0;
      charger_res_sel_o <= 2'h0;
    end
    else
    begin
      charger_enable_o  <= (charger_config[7:4] == rtcac_pkg::CHARGER_KEY)
                        && ((charger_config[3:2] == rtcac_pkg::DIODE_NONE)
                         || (charger_config[3:2] == rtcac_pkg::DIODE_ONE))
                        && (charger_config[1:0] != rtcac_pkg::RES_OFF);
      charger_diode_o   <= (charger_config[3:2] == rtcac_pkg::DIODE_ONE);
      charger_res_sel_o <= charger_config[1:0];
    end
  end

  a_alarm_a_every_sec: assert property (
    @(posedge clk_i) disable iff (reset_i)
    time_update_i && alarm_a_sec[7] && alarm_a_min[7] && alarm_a_hour[7]
      && alarm_a_day[7] |=> alarm_a_flag)
    else $error("alarm A missed with all masks set");

  a_alarm_b_minute: assert property (
    @(posedge clk_i) disable iff (reset_i)
    time_update_i && (time_sec_i != 8'h00) && !alarm_b_flag && !wr_control
      |=> !alarm_b_flag)
    else $error("alarm B fired away from second zero");

  a_flag_set_wins: assert property (
    @(posedge clk_i) disable iff (reset_i)
    time_update_i && match_a && wr_status |=> alarm_a_flag)
    else $error("alarm A set lost to clear");

  a_flag_write_one: assert property (
    @(posedge clk_i) disable iff (reset_i)
    alarm_b_flag && wr_status && reg_wdata_i[1] |=> alarm_b_flag)
    else $error("alarm B flag changed by writing one");

  a_halt_sticky: assert property (
    @(posedge clk_i) disable iff (reset_i)
    osc_halt_flag && !(wr_status && !reg_wdata_i[7]) |=> osc_halt_flag)
    else $error("halt flag dropped without a zero write");

  a_halt_on_stop: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (osc_state == rtcac_pkg::OSC_RUNNING) && osc_run_n |=> osc_halt_flag)
    else $error("stop did not raise halt flag");

  a_irq_pin_low: assert property (
    @(posedge clk_i) disable iff (reset_i)
    irq_mode_select && alarm_a_irq_enable && alarm_a_flag && !pin_float
      |=> !wave_or_irq_pin_o && !wave_or_irq_pin_oe_n_o)
    else $error("alarm A interrupt not on pin");

  a_irq_b_gate: assert property (
    @(posedge clk_i) disable iff (reset_i)
    irq_mode_select && !alarm_a_flag && !alarm_b_irq_enable && !pin_float
      |=> wave_or_irq_pin_o)
    else $error("alarm B interrupt without enable");

  a_pin_floats: assert property (
    @(posedge clk_i) disable iff (reset_i)
    backup_level && !backup_output_enable |=> wave_or_irq_pin_oe_n_o)
    else $error("pin driven on backup while disabled");

  a_wave_fast: assert property (
    @(posedge clk_i) disable iff (reset_i)
    !irq_mode_select && rate_select_hi && rate_select_lo && !pin_float
      |=> wave_or_irq_pin_o == $past(osc_level))
    else $error("fast square wave not on pin");

  a_charger_key: assert property (
    @(posedge clk_i) disable iff (reset_i)
    charger_config[7:4] != rtcac_pkg::CHARGER_KEY |=> !charger_enable_o)
    else $error("charger enabled without key");

endmodule : rtcac_core

// ### rtcac_osc_model.sv
// Crystal oscillator model feeding the block
module rtcac_osc_model (
  // Control
  input  wire logic run_i,
  // Oscillator
  output logic      osc_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Stopped crystal holds its level
  initial
  begin
    osc_o = 1'b0;
    forever
    begin
      #160;
      if (run_i === 1'b1)
        osc_o = ~osc_o;
    end
  end
endmodule : rtcac_osc_model

// ### tb_top.sv
// Testbench for the alarm, control and status block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic       clk_i;
  logic       reset_i;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;
  logic       upd;
  logic [7:0] tm [5];
  logic       osc;
  logic       bkp;
  logic       osc_en;
  logic       pin;
  logic       oe_n;
  logic       ch_en;
  logic       ch_d;
  logic [1:0] ch_r;
  logic [7:0] v;
  int         n_fail;
  int         check_count;

  rtcac_core uut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rdata_o(rdata), .time_update_i(upd), .time_sec_i(tm[0]),
    .time_min_i(tm[1]), .time_hour_i(tm[2]), .time_weekday_i(tm[3]),
    .time_date_i(tm[4]), .second_tick_o(), .osc_clk_i(osc), .backup_active_i(bkp),
    .osc_enable_o(osc_en), .wave_or_irq_pin_o(pin), .wave_or_irq_pin_oe_n_o(oe_n),
    .charger_enable_o(ch_en), .charger_diode_o(ch_d), .charger_res_sel_o(ch_r)
  );

  rtcac_osc_model osc_m (
    .run_i(osc_en),
    .osc_o(osc)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask : wr_reg

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    addr = a;
    @(negedge clk_i);
    chk(rdata, exp);
  endtask : chk_rd

  task automatic chk_pin(input logic ep, input logic eo);
    repeat (3) @(negedge clk_i);
    chk({6'h00, pin, oe_n}, {6'h00, ep, eo});
  endtask : chk_pin

  // Field index of compare position p; alarm B starts at minutes
  function automatic int fld(input int p, input bit s, input bit b);
    int q;
    q = p + b;
    return (q < 3) ? q : (s ? 3 : 4);
  endfunction : fld

  task automatic try(input bit b, input int bump, input logic exp);
    wr_reg(rtcac_pkg::ADDR_STATUS, 8'h00);
    tm = '{b ? 8'h00 : 8'h30, 8'h15, 8'h08, 8'h03, 8'h12};
    if (bump >= 0)
      tm[bump] = tm[bump] + 8'h01;
    @(negedge clk_i);
    upd = 1'b1;
    @(negedge clk_i);
    upd = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_rd(rtcac_pkg::ADDR_STATUS, {6'h00, b & exp, ~b & exp});
  endtask : try

  // Masks set for positions at or above k; hit bumps an ignored field
  task automatic alarm_case(input bit b, input int k, input bit s);
    logic [6:0] vals [3] = '{7'h30, 7'h15, 7'h08};
    logic [4:0] base;
    base = b ? rtcac_pkg::ADDR_ALARM_B_MIN : rtcac_pkg::ADDR_ALARM_A_SEC;
    for (int p = 0; p < 4 - b; p++)
      wr_reg(base + 5'(p), {k <= p, (p + b < 3) ? vals[p + b] : {s, s ? 6'h03 : 6'h12}});
    try(b, (k < 4 - b) ? fld(k, s, b) : (s ? 4 : 3), 1'b1);
    if (k > 0 || b)
      try(b, fld(k - 1, s, b), 1'b0);
  endtask : alarm_case

  task automatic cnt_wave(input logic [7:0] ctl, input int exp);
    int n;
    logic last;
    wr_reg(rtcac_pkg::ADDR_CONTROL, ctl);
    repeat (20) @(negedge clk_i);
    last = pin;
    n = 0;
    repeat (800)
    begin
      @(negedge clk_i);
      if (pin === 1'b1 && last === 1'b0)
        n++;
      last = pin;
    end
    check_count++;
    if (n < exp - 1 || n > exp + 1)
    begin
      n_fail++;
      $display("ERROR %0t wave edges %0d", $time, n);
    end
  endtask : cnt_wave

  task automatic wait_oe(input logic e);
    for (int i = 0; i < 20 && oe_n !== e; i++)
      @(negedge clk_i);
    chk({7'h00, oe_n}, {7'h00, e});
  endtask : wait_oe

  task report_and_stop;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial
  begin
    n_fail = 0;
    check_count = 0;
    reset_i = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    upd = 1'b0;
    bkp = 1'b0;
    tm = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (5) @(negedge clk_i);
    reset_i = 1'b0;
    chk_rd(rtcac_pkg::ADDR_CONTROL, 8'h18);
    chk_rd(rtcac_pkg::ADDR_STATUS, 8'h80);
    chk_rd(rtcac_pkg::ADDR_CHARGER, 8'h00);
    chk_rd(5'h1F, 8'h00);
    repeat (60) @(negedge clk_i);
    wr_reg(rtcac_pkg::ADDR_STATUS, 8'h00);
    chk_rd(rtcac_pkg::ADDR_STATUS, 8'h00);
    wr_reg(rtcac_pkg::ADDR_STATUS, 8'hFF);
    chk_rd(rtcac_pkg::ADDR_STATUS, 8'h00);
    for (int k = 0; k < 5; k++)
      for (int s = 0; s < 2; s++)
        alarm_case(1'b0, k, s[0]);
    for (int k = 0; k < 4; k++)
      for (int s = 0; s < 2; s++)
        alarm_case(1'b1, k, s[0]);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h06);
    try(1'b1, -1, 1'b1);
    chk_pin(1'b0, 1'b0);
    alarm_case(1'b0, 0, 1'b0);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h06);
    chk_pin(1'b1, 1'b0);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h07);
    chk_pin(1'b0, 1'b0);
    repeat (20) @(negedge clk_i);
    chk_pin(1'b0, 1'b0);
    wr_reg(rtcac_pkg::ADDR_STATUS, 8'h00);
    chk_pin(1'b1, 1'b0);
    cnt_wave(8'h00, 0);
    cnt_wave(8'h08, 13);
    cnt_wave(8'h10, 25);
    cnt_wave(8'h18, 100);
    bkp = 1'b1;
    wait_oe(1'b1);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h38);
    wait_oe(1'b0);
    bkp = 1'b0;
    wr_reg(rtcac_pkg::ADDR_STATUS, 8'h00);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h80);
    repeat (3) @(negedge clk_i);
    chk({7'h00, osc_en}, 8'h00);
    chk_rd(rtcac_pkg::ADDR_STATUS, 8'h80);
    wr_reg(rtcac_pkg::ADDR_CONTROL, 8'h18);
    repeat (3) @(negedge clk_i);
    chk({7'h00, osc_en}, 8'h01);
    for (int d = 0; d < 256; d++)
    begin
      v = 8'(d);
      wr_reg(rtcac_pkg::ADDR_CHARGER, v);
      @(negedge clk_i);
      chk({4'h0, ch_en, ch_d, ch_r}, {4'h0, v[7:4] == 4'hA && ^v[3:2] && v[1:0] != 2'h0,
          v[3:2] == 2'h2, v[1:0]});
      chk_rd(rtcac_pkg::ADDR_CHARGER, v);
    end
    report_and_stop();
  end
endmodule : tb_top
